// *** verilog/lsa_pkg.sv ***
// package of constants and types for the logic, subtract and swap datapath
`default_nettype none

package lsa_pkg;

  // widths and depth of the file register space, and the register port address width
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FADDR_W    = 7;
  localparam int unsigned FILE_DEPTH = 128;
  localparam int unsigned BUS_AW     = 8;

  // register port map: 8'h00..8'h7f reach the file registers directly
  localparam logic [7:0] FILE_LAST_ADDR = 8'h7f;
  localparam logic [7:0] ACC_ADDR       = 8'h80;
  localparam logic [7:0] STATUS_ADDR    = 8'h81;

  // status register field positions
  localparam int unsigned CARRY_BIT  = 0;
  localparam int unsigned NIBBLE_BIT = 1;
  localparam int unsigned ZERO_BIT   = 2;

  // values after reset
  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic       FLAG_RST = 1'b0;

  // cycles from an accepted operation to its done pulse
  localparam int unsigned EXEC_CYCLES = 2;

  // operation select encoding
  typedef enum logic [1:0] {
    XOR_IMMEDIATE_OP         = 2'b00,
    SUBTRACT_ACC_FROM_REG_OP = 2'b01,
    XOR_ACC_WITH_REG_OP      = 2'b10,
    NIBBLE_EXCHANGE_OP       = 2'b11
  } lsa_op_t;

  // sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } lsa_state_t;

  // read data source for the register port
  typedef enum logic [0:0] {
    RSRC_REG  = 1'b0,
    RSRC_FILE = 1'b1
  } lsa_rsrc_t;

  // whole state of the datapath outside the file register memory
  typedef struct packed {
    lsa_state_t      st;
    lsa_op_t         op;
    logic            dest;
    logic [7:0]      imm;
    logic [7:0]      acc;
    logic            carry;
    logic            nib;
    logic            zero;
    logic            done;
    logic            ready;
    lsa_rsrc_t       rsrc;
    logic [7:0]      rreg;
    logic [6:0]      faddr;
  } lsa_core_t;

endpackage

`default_nettype wire

// *** verilog/lsa_file_ram.sv ***
// dual-port file register memory with registered read data on both ports
`default_nettype none

module lsa_file_ram #(
  parameter int unsigned DW    = 8,
  parameter int unsigned AW    = 7,
  parameter int unsigned DEPTH = 128
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // port a, register port side
  input  wire logic [AW-1:0] a_addr,
  input  wire logic          a_we,
  input  wire logic [DW-1:0] a_wdata,
  output logic      [DW-1:0] a_rdata,
  // port b, execution side
  input  wire logic [AW-1:0] b_addr,
  input  wire logic          b_we,
  input  wire logic [DW-1:0] b_wdata,
  output logic      [DW-1:0] b_rdata
);

  logic [DW-1:0] mem [DEPTH];

  // array has no reset; a same-address write from both ports lets port b win
  always_ff @(posedge core_clk) begin
    if (a_we && !(b_we && (b_addr == a_addr))) begin
      mem[a_addr] <= a_wdata;
    end
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
  end

  // read data registered; a read in a write cycle returns the old byte
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      a_rdata <= '0;
      b_rdata <= '0;
    end else begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end

endmodule

`default_nettype wire

// *** verilog/lsa_alu.sv ***
// execution datapath for xor, subtract and nibble exchange on an 8-bit core
//
// How it works
// - xor immediate: accumulator xor literal into accumulator, only zero flag changes
// - subtract: register minus accumulator, two's complement, updates carry, nibble, zero
// - xor with register: accumulator xor register, only zero flag changes
// - subtract and xor register: select 0 writes accumulator, 1 writes register
// - nibble exchange swaps high and low nibbles and leaves all flags alone
// - nibble exchange: select 0 writes accumulator, 1 writes register
`default_nettype none

module lsa_alu (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // operation request
  input  wire logic        op_valid,
  input  wire logic [1:0]  op_sel,
  input  wire logic        op_dest,
  input  wire logic [6:0]  op_faddr,
  input  wire logic [7:0]  op_imm,
  // operation status
  output logic             op_ready,
  output logic             op_done,
  // architectural state view
  output logic [7:0]       acc_out,
  output logic             carry_flag,
  output logic             nibble_borrow_flag,
  output logic             zero_flag,
  // register port
  input  wire logic [7:0]  bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic [7:0]       bus_rdata
);

  lsa_pkg::lsa_core_t s_q;
  lsa_pkg::lsa_core_t s_d;

  // memory port nets
  logic [6:0] b_addr;
  logic       b_we;
  logic [7:0] b_wdata;
  logic [7:0] b_rdata;
  logic [7:0] a_rdata;
  logic       a_we;

  // zero test shared by every flag-updating operation
  function automatic logic is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  // file space decode, shared by the read and write paths of the register port
  function automatic logic is_file(input logic [7:0] a);
    return (a <= lsa_pkg::FILE_LAST_ADDR);
  endfunction

  // file register space, addresses 8'h00..8'h7f of the register port
  lsa_file_ram #(
    .DW    (lsa_pkg::DATA_W),
    .AW    (lsa_pkg::FADDR_W),
    .DEPTH (lsa_pkg::FILE_DEPTH)
  ) u_ram (
    .core_clk (core_clk),
    .rst      (rst),
    .a_addr   (bus_addr[6:0]),
    .a_we     (a_we),
    .a_wdata  (bus_wdata),
    .a_rdata  (a_rdata),
    .b_addr   (b_addr),
    .b_we     (b_we),
    .b_wdata  (b_wdata),
    .b_rdata  (b_rdata)
  );

  // register port writes to the file space
  assign a_we = bus_wr && is_file(bus_addr);

  // the operand address is latched in the state struct at accept, so the
  // write-back of the execution cycle hits the byte that was read
  // limitation: a bus write to that byte while the op runs is overwritten
  // when the result goes back to it

  // next-state logic for sequencer, accumulator, flags and register port
  always_comb begin
    logic [7:0] res;
    logic [8:0] diff;
    logic [4:0] ndiff;
    logic       to_acc;
    res     = 8'h00;
    diff    = 9'h000;
    ndiff   = 5'h00;
    to_acc  = 1'b1;
    s_d     = s_q;
    b_we    = 1'b0;
    b_wdata = 8'h00;
    b_addr  = s_q.faddr;
    s_d.done = 1'b0;

    // register port read: data stands in the next cycle only
    s_d.rsrc = lsa_pkg::RSRC_REG;
    s_d.rreg = 8'h00;
    if (bus_rd) begin
      if (is_file(bus_addr)) begin
        s_d.rsrc = lsa_pkg::RSRC_FILE;
      end else if (bus_addr == lsa_pkg::ACC_ADDR) begin
        s_d.rreg = s_q.acc;
      end else if (bus_addr == lsa_pkg::STATUS_ADDR) begin
        s_d.rreg[lsa_pkg::CARRY_BIT]  = s_q.carry;
        s_d.rreg[lsa_pkg::NIBBLE_BIT] = s_q.nib;
        s_d.rreg[lsa_pkg::ZERO_BIT]   = s_q.zero;
      end
    end

    // register port writes; the execution cycle below overrides them
    if (bus_wr && (bus_addr == lsa_pkg::ACC_ADDR)) begin
      s_d.acc = bus_wdata;
    end
    if (bus_wr && (bus_addr == lsa_pkg::STATUS_ADDR)) begin
      s_d.carry = bus_wdata[lsa_pkg::CARRY_BIT];
      s_d.nib   = bus_wdata[lsa_pkg::NIBBLE_BIT];
      s_d.zero  = bus_wdata[lsa_pkg::ZERO_BIT];
    end

    case (s_q.st)
      lsa_pkg::ST_IDLE: begin
        // accept and start the operand read in the same cycle
        if (op_valid && s_q.ready) begin
          s_d.op    = lsa_pkg::lsa_op_t'(op_sel);
          s_d.dest  = op_dest;
          s_d.imm   = op_imm;
          s_d.faddr = op_faddr;
          b_addr    = op_faddr;
          s_d.ready = 1'b0;
          s_d.st    = lsa_pkg::ST_EXEC;
        end
      end
      lsa_pkg::ST_EXEC: begin
        // operand byte from the file space is valid now
        case (s_q.op)
          lsa_pkg::XOR_IMMEDIATE_OP: begin
            res      = s_q.acc ^ s_q.imm;
            s_d.zero = is_zero(res);
            to_acc   = 1'b1;
          end
          lsa_pkg::SUBTRACT_ACC_FROM_REG_OP: begin
            // add of the inverted accumulator plus one; carry out means no borrow
            diff      = {1'b0, b_rdata} + {1'b0, ~s_q.acc} + 9'h001;
            ndiff     = {1'b0, b_rdata[3:0]} + {1'b0, ~s_q.acc[3:0]} + 5'h01;
            res       = diff[7:0];
            s_d.carry = diff[8];
            s_d.nib   = ndiff[4];
            s_d.zero  = is_zero(res);
            to_acc    = !s_q.dest;
          end
          lsa_pkg::XOR_ACC_WITH_REG_OP: begin
            res      = s_q.acc ^ b_rdata;
            s_d.zero = is_zero(res);
            to_acc   = !s_q.dest;
          end
          lsa_pkg::NIBBLE_EXCHANGE_OP: begin
            // flags deliberately untouched here
            res    = {b_rdata[3:0], b_rdata[7:4]};
            to_acc = !s_q.dest;
          end
          default: begin
            res    = s_q.acc;
            to_acc = 1'b1;
          end
        endcase
        // route the result to the chosen destination
        if (to_acc) begin
          s_d.acc = res;
        end else begin
          b_we    = 1'b1;
          b_wdata = res;
        end
        s_d.done  = 1'b1;
        s_d.ready = 1'b1;
        s_d.st    = lsa_pkg::ST_IDLE;
      end
      default: begin
        s_d.st    = lsa_pkg::ST_IDLE;
        s_d.ready = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q.st    <= lsa_pkg::ST_IDLE;
      s_q.op    <= lsa_pkg::XOR_IMMEDIATE_OP;
      s_q.dest  <= 1'b0;
      s_q.imm   <= 8'h00;
      s_q.acc   <= lsa_pkg::ACC_RST;
      s_q.carry <= lsa_pkg::FLAG_RST;
      s_q.nib   <= lsa_pkg::FLAG_RST;
      s_q.zero  <= lsa_pkg::FLAG_RST;
      s_q.done  <= 1'b0;
      s_q.ready <= 1'b1;
      s_q.rsrc  <= lsa_pkg::RSRC_REG;
      s_q.rreg  <= 8'h00;
      s_q.faddr <= 7'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state flops
  assign op_ready           = s_q.ready;
  assign op_done            = s_q.done;
  assign acc_out            = s_q.acc;
  assign carry_flag         = s_q.carry;
  assign nibble_borrow_flag = s_q.nib;
  assign zero_flag          = s_q.zero;
  // file bytes come from the memory's own read flop, so only a select sits after it
  assign bus_rdata = (s_q.rsrc == lsa_pkg::RSRC_FILE) ? a_rdata : s_q.rreg;

endmodule

`default_nettype wire

// *** dv/lsa_alu_sva.sv ***
// assertions on the operation port and state outputs of the datapath
`default_nettype none
module lsa_alu_sva (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // operation port
  input wire logic       op_valid,
  input wire logic [1:0] op_sel,
  input wire logic       op_dest,
  input wire logic [7:0] op_imm,
  input wire logic       op_ready,
  input wire logic       op_done,
  // state view
  input wire logic [7:0] acc_out,
  input wire logic       carry_flag,
  input wire logic       nibble_borrow_flag,
  input wire logic       zero_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic       tk;
  logic [2:0] fz;
  // bus writes during an op would blur these, so the bench keeps them apart
  assign tk = op_valid && op_ready;
  assign fz = {carry_flag, nibble_borrow_flag, zero_flag};
  done_timing_a: assert property (tk |=> !op_ready ##1 (op_done && op_ready))
    else $error("op timing wrong");
  done_pulse_a: assert property (op_done |=> !op_done)
    else $error("done not a pulse");
  ximm_result_a: assert property (tk && op_sel == 2'h0 |-> ##2
    acc_out == ($past(acc_out, 2) ^ $past(op_imm, 2))) else $error("xor literal wrong");
  ximm_flags_a: assert property (tk && op_sel == 2'h0 |-> ##2 fz[2:1] == $past(fz[2:1], 2))
    else $error("xor literal hit carry");
  xreg_flags_a: assert property (tk && op_sel == 2'h2 |-> ##2 fz[2:1] == $past(fz[2:1], 2))
    else $error("xor reg hit carry");
  swap_flags_a: assert property (tk && op_sel == 2'h3 |-> ##2 fz == $past(fz, 2))
    else $error("swap hit flags");
  dest_reg_a: assert property (tk && op_sel != 2'h0 && op_dest |-> ##2
    acc_out == $past(acc_out, 2)) else $error("acc changed on reg dest");
  acc_zero_a: assert property (tk && op_sel != 2'h3 && !op_dest |-> ##2
    zero_flag == (acc_out == 8'h00)) else $error("zero flag wrong");
endmodule
bind lsa_alu lsa_alu_sva u_sva (.*);
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the logic, subtract and swap datapath
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        op_valid = 1'b0, op_dest = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [1:0]  op_sel = 2'h0;
  logic [6:0]  op_faddr = 7'h00;
  logic [7:0]  op_imm = 8'h00, bus_addr = 8'h00, bus_wdata = 8'h00;
  logic        op_ready, op_done, carry_flag, nibble_borrow_flag, zero_flag;
  logic [7:0]  acc_out, bus_rdata, acc_m = 8'h00;
  logic [7:0]  mem [128];
  logic [2:0]  flg_m = 3'h0; // carry, nibble, zero
  logic [31:0] sd = 32'h0a00be53;
  logic [7:0]  rq [$];
  logic [10:0] oq [$];
  logic        rd_seen = 1'b0;
  int          errors = 0, samples_checked = 0, cycles = 0;
  always #12.5 core_clk = ~core_clk;
  lsa_alu dut (.core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_sel(op_sel),
    .op_dest(op_dest), .op_faddr(op_faddr), .op_imm(op_imm), .op_ready(op_ready),
    .op_done(op_done), .acc_out(acc_out), .carry_flag(carry_flag),
    .nibble_borrow_flag(nibble_borrow_flag), .zero_flag(zero_flag), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp_bus(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t bus exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_op(input logic [10:0] e, input logic [10:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t op exp %h got %h", $time, e, g);
    end
  endtask
  function automatic logic [2:0] fz_now();
    return {carry_flag, nibble_borrow_flag, zero_flag};
  endfunction
  // monitor: read data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    rd_seen <= bus_rd;
    if (rd_seen) cmp_bus(rq.pop_front(), bus_rdata);
    if (op_done === 1'b1) cmp_op(oq.pop_front(), {acc_out, fz_now()});
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge core_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_rd <= 1'b0;
  endtask
  // model the op first so the note is queued before done can show
  task automatic run_op(input logic [1:0] s, input logic d, input logic [6:0] a,
                        input logic [7:0] k);
    logic [7:0] f, r;
    f = mem[a];
    case (s)
      2'h0: r = acc_m ^ k;
      2'h1: begin
        r = f - acc_m;
        flg_m[2:1] = {f >= acc_m, f[3:0] >= acc_m[3:0]};
      end
      2'h2: r = acc_m ^ f;
      default: r = {f[3:0], f[7:4]};
    endcase
    if (s != 2'h3) flg_m[0] = (r == 8'h00);
    if (d && s != 2'h0) mem[a] = r;
    else acc_m = r;
    oq.push_back({acc_m, flg_m});
    @(posedge core_clk);
    op_valid <= 1'b1;
    {op_sel, op_dest, op_faddr, op_imm} <= {s, d, a, k};
    @(posedge core_clk);
    op_valid <= 1'b0;
    repeat (lsa_pkg::EXEC_CYCLES) @(posedge core_clk);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h80, 8'h00);
    rd(8'h81, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 128; i++) begin
      sd = xs(sd);
      mem[i] = sd[7:0];
      wr(i[7:0], sd[7:0]);
    end
    wr(8'h9a, 8'h55);
    rd(8'h9a, 8'h00);
    $display("test registers done");
    // equal operands: zero result with no borrow anywhere
    wr(8'h7f, acc_m);
    mem[127] = acc_m;
    run_op(2'h1, 1'b1, 7'h7f, 8'h00);
    for (int i = 0; i < 300; i++) begin
      sd = xs(sd);
      if (sd[20]) wr(8'h80, sd[31:24]);
      if (sd[20]) acc_m = sd[31:24];
      // status is writable; only bits 2:0 are kept
      if (sd[19]) wr(8'h81, sd[31:24]);
      if (sd[19]) flg_m = {sd[24], sd[25], sd[26]};
      run_op(sd[1:0], sd[2], sd[9:3], sd[17:10]);
      rd(sd[2] ? {1'b0, sd[9:3]} : 8'h80, sd[2] ? mem[sd[9:3]] : acc_m);
      rd(8'h81, {5'h00, flg_m[0], flg_m[1], flg_m[2]});
    end
    repeat (3) @(posedge core_clk);
    $display("test operations done");
    // second reset mid-run: accumulator and flags clear, file bytes are kept
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    acc_m = 8'h00;
    flg_m = 3'h0;
    rd(8'h80, acc_m);
    rd(8'h81, 8'h00);
    rd(8'h05, mem[5]);
    run_op(2'h2, 1'b0, 7'h05, 8'h00);
    repeat (3) @(posedge core_clk);
    $display("test mid reset done");
    test_done();
  end
endmodule
`default_nettype wire
